/* dv/mmd_decoder_monitor.sv */
/*
  Port checker for the memory map decoder.
  Assumes it is bound to every mmd_decoder instance.
*/
`timescale 1ns/1ns
module mmd_chk
(
  // Inputs watched
  input wire        clk_i,
  input wire        rstn_i,
  input wire [15:0] acc_addr_i,
  input wire        acc_fetch_i,
  input wire        external_access_select_i,
  input wire        nmi_i,
  // Outputs watched
  input wire        sel_sfr_o,
  input wire        sel_ram_o,
  input wire        sel_port_o,
  input wire        sel_prog_o,
  input wire        sel_ext_o,
  input wire        acc_done_o,
  input wire        fetch_type_output_o,
  input wire        rd_n_o,
  input wire        low_byte_write_strobe_n_o,
  input wire        high_byte_write_strobe_n_o,
  input wire        bus16_o,
  input wire        nmi_vec_o,
  input wire [15:0] nmi_addr_o,
  input wire        half_rate_clock_o
);
  wire intl = sel_sfr_o | sel_ram_o | sel_port_o | sel_prog_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_one_region: assert property ($onehot0({sel_sfr_o, sel_ram_o, sel_port_o, sel_prog_o, sel_ext_o}))
    else $error("more than one region selected");
  a_sfr_range: assert property (sel_sfr_o |-> acc_addr_i <= 16'h0017 && !acc_fetch_i)
    else $error("register select outside its range");
  a_ram_range: assert property (sel_ram_o |-> acc_addr_i inside {[16'h0018:16'h01FF]} && !acc_fetch_i)
    else $error("ram select outside its range");
  a_port_pair: assert property (sel_port_o |-> acc_addr_i[15:1] == 15'h0FFF)
    else $error("port select outside its pair");
  a_prog_select: assert property (sel_prog_o |-> external_access_select_i && acc_addr_i inside {[16'h2000:16'h5FFF]})
    else $error("program memory select wrong");
  a_top_external: assert property (intl |-> acc_addr_i < 16'h6000)
    else $error("upper space decoded internally");
  a_read_strobe: assert property (!rd_n_o |-> sel_ext_o)
    else $error("read strobe on internal access");
  a_write_strobe: assert property (!(low_byte_write_strobe_n_o && high_byte_write_strobe_n_o) |-> sel_ext_o && rd_n_o)
    else $error("write strobe outside external write");
  a_fetch_flag: assert property (fetch_type_output_o |-> sel_ext_o && !rd_n_o && acc_fetch_i)
    else $error("fetch flag outside external fetch");
  a_width_ext: assert property (bus16_o |-> sel_ext_o)
    else $error("wide cycle outside external access");
  a_nmi_vector: assert property ($rose(nmi_i) |=> nmi_vec_o && nmi_addr_o == 16'h203E)
    else $error("nmi vector missing");
  a_half_rate: assert property ($past(rstn_i) |-> half_rate_clock_o != $past(half_rate_clock_o))
    else $error("clock output not at half rate");
  a_internal_done: assert property ($rose(intl) |=> acc_done_o)
    else $error("internal access not done in time");
  c_fetch: cover property (sel_ext_o && fetch_type_output_o);
  c_prog: cover property (sel_prog_o);
  c_wide: cover property (bus16_o);
  c_nmi: cover property (nmi_vec_o);
endmodule
bind mmd_decoder mmd_chk u_chk
(
  .clk_i                      (clk_i),
  .rstn_i                     (rstn_i),
  .acc_addr_i                 (acc_addr_i),
  .acc_fetch_i                (acc_fetch_i),
  .external_access_select_i   (external_access_select_i),
  .nmi_i                      (nmi_i),
  .sel_sfr_o                  (sel_sfr_o),
  .sel_ram_o                  (sel_ram_o),
  .sel_port_o                 (sel_port_o),
  .sel_prog_o                 (sel_prog_o),
  .sel_ext_o                  (sel_ext_o),
  .acc_done_o                 (acc_done_o),
  .fetch_type_output_o        (fetch_type_output_o),
  .rd_n_o                     (rd_n_o),
  .low_byte_write_strobe_n_o  (low_byte_write_strobe_n_o),
  .high_byte_write_strobe_n_o (high_byte_write_strobe_n_o),
  .bus16_o                    (bus16_o),
  .nmi_vec_o                  (nmi_vec_o),
  .nmi_addr_o                 (nmi_addr_o),
  .half_rate_clock_o          (half_rate_clock_o)
);

/* dv/mmd_decoder_tb.sv */
/*
  Testbench for the memory map decoder.
  Assumes the checker is bound and the partner model sits on the bus pins.
*/
`timescale 1ns/1ns
module mmd_decoder_tb;
  logic clk_i = 0, rstn_i = 0, acc_req_i = 0, acc_write_i = 0, acc_fetch_i = 0, acc_word_i = 0;
  logic cfg_load_i = 0, external_access_select_i = 1, nmi_i = 0, wide = 0;
  logic [15:0] acc_addr_i = 16'h0000;
  logic [7:0]  chip_config_byte_i = 8'h00;
  logic [3:0]  waits = 4'h0;
  wire bus_width_i, ready_i, sel_sfr_o, sel_ram_o, sel_port_o, sel_prog_o, sel_ext_o, acc_done_o;
  wire fetch_type_output_o, rd_n_o, low_byte_write_strobe_n_o, high_byte_write_strobe_n_o;
  wire bus16_o, nmi_vec_o, half_rate_clock_o;
  wire [15:0] nmi_addr_o;
  int err_count = 0, checks_done = 0, cyc;
  logic [4:0] sv;
  logic rdl, wll, whl, ft, b16;
  mmd_decoder dut (.clk_i(clk_i), .rstn_i(rstn_i), .acc_req_i(acc_req_i), .acc_addr_i(acc_addr_i),
    .acc_write_i(acc_write_i), .acc_fetch_i(acc_fetch_i), .acc_word_i(acc_word_i), .cfg_load_i(cfg_load_i),
    .chip_config_byte_i(chip_config_byte_i), .external_access_select_i(external_access_select_i),
    .bus_width_i(bus_width_i), .ready_i(ready_i), .nmi_i(nmi_i), .sel_sfr_o(sel_sfr_o), .sel_ram_o(sel_ram_o),
    .sel_port_o(sel_port_o), .sel_prog_o(sel_prog_o), .sel_ext_o(sel_ext_o), .acc_done_o(acc_done_o),
    .fetch_type_output_o(fetch_type_output_o), .rd_n_o(rd_n_o),
    .low_byte_write_strobe_n_o(low_byte_write_strobe_n_o),
    .high_byte_write_strobe_n_o(high_byte_write_strobe_n_o),
    .bus16_o(bus16_o), .nmi_vec_o(nmi_vec_o), .nmi_addr_o(nmi_addr_o), .half_rate_clock_o(half_rate_clock_o));
  mmd_ext_mem u_mem (.clk_i(clk_i), .sel_ext_i(sel_ext_o), .waits_i(waits), .wide_i(wide),
    .ready_o(ready_i), .width_o(bus_width_i));
  initial forever #25 clk_i = ~clk_i;
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask
  task setcfg(input logic [7:0] b);
    @(negedge clk_i);
    chip_config_byte_i = b;
    cfg_load_i = 1;
    @(negedge clk_i);
    cfg_load_i = 0;
  endtask
  // Request held until done; selects and strobes are gathered on the way
  task acc(input logic [15:0] a, input logic w, input logic f, input logic d);
    @(negedge clk_i);
    {acc_req_i, acc_addr_i, acc_write_i, acc_fetch_i, acc_word_i} = {1'b1, a, w, f, d};
    {sv, rdl, wll, whl, ft, b16} = 10'h000;
    cyc = 0;
    while (acc_done_o !== 1'b1 && cyc < 40)
    begin
      @(negedge clk_i);
      cyc++;
      sv = sv | {sel_ext_o, sel_prog_o, sel_port_o, sel_ram_o, sel_sfr_o};
      {rdl, wll, whl} = {rdl, wll, whl} | ~{rd_n_o, low_byte_write_strobe_n_o, high_byte_write_strobe_n_o};
      {ft, b16} = {ft, b16} | {fetch_type_output_o, bus16_o};
    end
    acc_req_i = 0;
    if (cyc >= 40)
    begin
      $display("BAD acc_done_o exp 1 got 0");
      err_count++;
      conclude();
    end
  endtask
  task t_map;
    logic [15:0] am [12];
    logic [4:0]  sm [12];
    am = '{16'h0000, 16'h0017, 16'h0018, 16'h01FF, 16'h0200, 16'h1FFD,
           16'h1FFE, 16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000, 16'hFFFF};
    sm = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h10, 5'h10, 5'h04, 5'h04, 5'h08, 5'h08, 5'h10, 5'h10};
    for (int i = 0; i < 12; i++)
    begin
      acc(am[i], 0, 0, 0);
      chk("region", 16'(sm[i]), 16'(sv));
      chk("read strobe", 16'(sm[i][4]), 16'(rdl));
    end
    $display("test map done");
  endtask
  task t_ea;
    external_access_select_i = 0;
    acc(16'h2000, 0, 0, 0);
    chk("select low", 16'h0010, 16'(sv));
    acc(16'h5FFF, 0, 0, 0);
    chk("select low", 16'h0010, 16'(sv));
    external_access_select_i = 1;
    acc(16'h2080, 0, 0, 0);
    chk("select high", 16'h0008, 16'(sv));
    $display("test select done");
  endtask
  task t_fetch;
    acc(16'h0010, 0, 1, 0);
    chk("fetch low", 16'h0010, 16'(sv));
    chk("fetch flag", 16'h0001, 16'(ft));
    acc(16'h01FF, 0, 1, 0);
    chk("fetch ram", 16'h0010, 16'(sv));
    acc(16'h6000, 0, 0, 0);
    chk("data flag", 16'h0000, 16'(ft));
    $display("test fetch done");
  endtask
  task t_wr;
    logic [7:0]  cm [6];
    logic [15:0] am [6];
    logic [1:0]  em [6];
    logic        wm [6];
    cm = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
    am = '{16'h6000, 16'h6001, 16'h6000, 16'h6001, 16'h6000, 16'h0018};
    wm = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    em = '{2'h2, 2'h3, 2'h2, 2'h1, 2'h3, 2'h0};
    for (int i = 0; i < 6; i++)
    begin
      setcfg(cm[i]);
      acc(am[i], 1, 0, wm[i]);
      chk("write strobes", 16'(em[i]), 16'({wll, whl}));
      chk("no read", 16'h0000, 16'(rdl));
    end
    $display("test write done");
  endtask
  task t_width;
    setcfg(8'h00);
    wide = 1;
    acc(16'h6000, 0, 0, 0);
    chk("width fixed", 16'h0000, 16'(b16));
    setcfg(8'h02);
    acc(16'h6000, 0, 0, 0);
    chk("width pin high", 16'h0001, 16'(b16));
    wide = 0;
    acc(16'h6000, 0, 0, 0);
    chk("width pin low", 16'h0000, 16'(b16));
    $display("test width done");
  endtask
  task t_wait;
    waits = 4'h3;
    acc(16'h6000, 0, 0, 0);
    chk("slow cycles", 16'h0005, 16'(cyc));
    acc(16'h0018, 0, 0, 0);
    chk("internal cycles", 16'h0002, 16'(cyc));
    waits = 4'h0;
    acc(16'h6000, 0, 0, 0);
    chk("fast cycles", 16'h0002, 16'(cyc));
    $display("test wait done");
  endtask
  task t_nmi;
    @(negedge clk_i);
    nmi_i = 1;
    @(negedge clk_i);
    chk("nmi pulse", 16'h0001, 16'(nmi_vec_o));
    chk("nmi vector", 16'h203E, nmi_addr_o);
    @(negedge clk_i);
    chk("nmi single", 16'h0000, 16'(nmi_vec_o));
    nmi_i = 0;
    $display("test nmi done");
  endtask
  task t_clk;
    logic h;
    @(negedge clk_i);
    h = half_rate_clock_o;
    @(negedge clk_i);
    chk("clock out", {15'h0000, ~h}, {15'h0000, half_rate_clock_o});
    $display("test clock done");
  endtask
  initial
  begin
    repeat (10) @(negedge clk_i);
    rstn_i = 1;
    t_map();
    t_ea();
    t_fetch();
    t_wr();
    t_width();
    t_wait();
    t_nmi();
    t_clk();
    conclude();
  end
endmodule

/* dv/mmd_ext_mem.sv */
/*
  External memory partner: answers ready after a set number of waits.
  Assumes a cycle lasts while sel_ext_i is high.
*/
`timescale 1ns/1ns
module mmd_ext_mem
(
  // Clock and cycle
  input  wire       clk_i,
  input  wire       sel_ext_i,
  input  wire [3:0] waits_i,
  input  wire       wide_i,
  // Pins to the device
  output wire       ready_o,
  output wire       width_o
);
  logic [4:0] n_q = 5'h00;
  always @(negedge clk_i)
    n_q <= !sel_ext_i ? 5'h00 : (n_q <= {1'b0, waits_i} ? n_q + 5'h01 : n_q);
  // Low ready also outside cycles, which the device must ignore;
  // inside a cycle exactly waits_i edges see ready low
  assign ready_o = n_q > {1'b0, waits_i};
  assign width_o = wide_i;
endmodule

/* verilog/mmd_clkdiv.v */
/*
  Half-rate clock output generator.
  Assumes clk_i is the oscillator clock; output toggles every rising edge.
*/
`timescale 1ns/1ns
module mmd_clkdiv
(
  // Clock and reset
  input  wire clk_i,
  input  wire rstn_i,
  // Divided clock
  output reg  half_rate_clock_o
);

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      half_rate_clock_o <= 1'b0;
    else
      half_rate_clock_o <= ~half_rate_clock_o;
  end

endmodule

/* verilog/mmd_decoder.v */
/*
  Memory map decoder and external bus cycle qualifier.
  Assumes one core access request at a time, held until acc_done_o, and
  synchronous pin inputs. Strobe timing within the cycle is simplified.
  Reserved locations are decoded like their neighbours; code must keep
  away from them rather than rely on any bus error.
*/
// What this block does
// - 6000H-FFFFH always go external
// - 2000H-5FFFH internal or external by select
// - Select high: 2000H-5FFFH on-chip, else external
// - 0018H-01FFH register RAM for data; fetches go on bus
// - 0000H-0017H decode as special-function registers
// - Fetches from 0000H-01FFH forced external
// - Config bit 1 enables sampled width input
// - NMI rising edge vectors through 203EH
// - Fetch-type high for fetches, external only
// - Clock output at half oscillator rate
// - Read strobe only for external reads
// - Write or low-byte strobe per write mode
// - High-byte strobe, the same in both write modes
// - Ready lengthens external cycles only
`timescale 1ns/1ns
`include "mmd_regs.vh"
module mmd_decoder
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rstn_i,
  // Core access request
  input  wire        acc_req_i,
  input  wire [15:0] acc_addr_i,
  input  wire        acc_write_i,
  input  wire        acc_fetch_i,
  input  wire        acc_word_i,
  // Configuration
  input  wire        cfg_load_i,
  input  wire [7:0]  chip_config_byte_i,
  input  wire        external_access_select_i,
  // Pins
  input  wire        bus_width_i,
  input  wire        ready_i,
  input  wire        nmi_i,
  // Region selects and access done
  output reg         sel_sfr_o,
  output reg         sel_ram_o,
  output reg         sel_port_o,
  output reg         sel_prog_o,
  output reg         sel_ext_o,
  output reg         acc_done_o,
  // External bus qualifiers
  output reg         fetch_type_output_o,
  output reg         rd_n_o,
  output reg         low_byte_write_strobe_n_o,
  output reg         high_byte_write_strobe_n_o,
  output reg         bus16_o,
  // Interrupt vector
  output reg         nmi_vec_o,
  output reg  [15:0] nmi_addr_o,
  // Clock pin
  output wire        half_rate_clock_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function in_rng;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // Fetches are tested first: code never runs from the register file
  function [2:0] region;
    input [15:0] a;
    input        fetch;
    input        ea;
    begin
      if (fetch && in_rng(a, `MMD_SFR_LO, `MMD_RAM_HI))
        region = `MMD_RGN_EXT;
      else if (in_rng(a, `MMD_SFR_LO, `MMD_SFR_HI))
        region = `MMD_RGN_SFR;
      else if (in_rng(a, `MMD_RAM_LO, `MMD_RAM_HI))
        region = `MMD_RGN_RAM;
      else if (in_rng(a, `MMD_LOWEXT_LO, `MMD_LOWEXT_HI))
        region = `MMD_RGN_EXT;
      else if (in_rng(a, `MMD_PORT_LO, `MMD_PORT_HI))
        region = `MMD_RGN_PORT;
      else if (in_rng(a, `MMD_PROG_LO, `MMD_PROG_HI))
        region = ea ? `MMD_RGN_PROG : `MMD_RGN_EXT;
      else
        region = `MMD_RGN_EXT;
    end
  endfunction

  // ----------------------------------------------------------------
  // Target and strobe helpers
  // ----------------------------------------------------------------
  // One-hot target select, bit order {ext, prog, port, ram, sfr}
  function [4:0] rgn_onehot;
    input [2:0] r;
    begin
      case (r)
        `MMD_RGN_SFR:  rgn_onehot = 5'h01;
        `MMD_RGN_RAM:  rgn_onehot = 5'h02;
        `MMD_RGN_PORT: rgn_onehot = 5'h04;
        `MMD_RGN_PROG: rgn_onehot = 5'h08;
        default:       rgn_onehot = 5'h10;
      endcase
    end
  endfunction

  // Active-low {low, high} write strobes; both idle unless writing out
  function [1:0] wr_strobes;
    input wr;
    input split;
    input lo;
    input hi;
    begin
      if (!wr)
        wr_strobes = 2'h3;
      else if (split)
        wr_strobes = {~lo, ~hi};
      else
        wr_strobes = {1'b0, ~hi};
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration latch
  // ----------------------------------------------------------------
  reg [`MMD_CFG_WIDTH-1:0] cfg_q;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cfg_q <= `MMD_CFG_RESET;
    else if (cfg_load_i)
      cfg_q <= chip_config_byte_i;
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_INT  = 2'h1;
  localparam ST_EXT  = 2'h2;
  localparam ST_DONE = 2'h3;

  reg  [1:0] state_q;
  reg  [1:0] state_d;
  wire [2:0] rgn;
  wire       wide;
  wire       lo_byte;
  wire       hi_byte;

  assign rgn = region(acc_addr_i, acc_fetch_i, external_access_select_i);
  // Width is sampled at cycle start so it cannot change mid-cycle
  assign wide = cfg_q[`MMD_CFG_DYNWIDTH] & bus_width_i;
  assign lo_byte = acc_word_i ? 1'b1 : ~acc_addr_i[0];
  assign hi_byte = acc_word_i ? 1'b1 : acc_addr_i[0];

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (acc_req_i)
          state_d = (rgn == `MMD_RGN_EXT) ? ST_EXT : ST_INT;
      ST_INT:
        state_d = ST_DONE;
      ST_EXT:
        // Ready is looked at only here, never between cycles
        if (ready_i)
          state_d = ST_DONE;
      ST_DONE:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Cycle qualifier next values
  // ----------------------------------------------------------------
  // Everything is released at cycle end so nothing lingers into the
  // idle slot that separates two accesses
  reg  [4:0] sel_d;
  reg        fetch_d;
  reg        rd_n_d;
  reg        strb_lo_n_d;
  reg        strb_hi_n_d;
  reg        bus16_d;
  wire       take;
  wire       cyc_end;
  wire       ext;

  assign take    = (state_q == ST_IDLE) && acc_req_i;
  assign cyc_end = (state_d == ST_DONE) || (state_q == ST_DONE);
  assign ext     = (rgn == `MMD_RGN_EXT);

  always @*
  begin
    sel_d       = {sel_ext_o, sel_prog_o, sel_port_o, sel_ram_o, sel_sfr_o};
    fetch_d     = fetch_type_output_o;
    rd_n_d      = rd_n_o;
    strb_lo_n_d = low_byte_write_strobe_n_o;
    strb_hi_n_d = high_byte_write_strobe_n_o;
    bus16_d     = bus16_o;
    if (take)
    begin
      // Internal targets keep the external bus quiet
      sel_d                      = rgn_onehot(rgn);
      fetch_d                    = ext & acc_fetch_i & ~acc_write_i;
      rd_n_d                     = ~ext | acc_write_i;
      bus16_d                    = ext & wide;
      {strb_lo_n_d, strb_hi_n_d} = wr_strobes(ext & acc_write_i, cfg_q[`MMD_CFG_WRMODE], lo_byte, hi_byte);
    end
    else if (cyc_end)
    begin
      sel_d       = 5'h00;
      fetch_d     = 1'b0;
      rd_n_d      = 1'b1;
      strb_lo_n_d = 1'b1;
      strb_hi_n_d = 1'b1;
      bus16_d     = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q                    <= ST_IDLE;
      sel_sfr_o                  <= 1'b0;
      sel_ram_o                  <= 1'b0;
      sel_port_o                 <= 1'b0;
      sel_prog_o                 <= 1'b0;
      sel_ext_o                  <= 1'b0;
      acc_done_o                 <= 1'b0;
      fetch_type_output_o        <= 1'b0;
      rd_n_o                     <= 1'b1;
      low_byte_write_strobe_n_o  <= 1'b1;
      high_byte_write_strobe_n_o <= 1'b1;
      bus16_o                    <= 1'b0;
    end
    else
    begin
      state_q                    <= state_d;
      acc_done_o                 <= (state_d == ST_DONE);
      sel_sfr_o                  <= sel_d[0];
      sel_ram_o                  <= sel_d[1];
      sel_port_o                 <= sel_d[2];
      sel_prog_o                 <= sel_d[3];
      sel_ext_o                  <= sel_d[4];
      fetch_type_output_o        <= fetch_d;
      rd_n_o                     <= rd_n_d;
      low_byte_write_strobe_n_o  <= strb_lo_n_d;
      high_byte_write_strobe_n_o <= strb_hi_n_d;
      bus16_o                    <= bus16_d;
    end
  end

  // ----------------------------------------------------------------
  // Nonmaskable interrupt edge
  // ----------------------------------------------------------------
  // A pin held high gives one pulse only; the vector needs a fresh rise
  reg nmi_q;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      nmi_q      <= 1'b0;
      nmi_vec_o  <= 1'b0;
      nmi_addr_o <= 16'h0000;
    end
    else
    begin
      nmi_q      <= nmi_i;
      nmi_vec_o  <= nmi_i & ~nmi_q;
      nmi_addr_o <= `MMD_NMI_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Clock output
  // ----------------------------------------------------------------
  mmd_clkdiv u_clkdiv
  (
    .clk_i             (clk_i),
    .rstn_i            (rstn_i),
    .half_rate_clock_o (half_rate_clock_o)
  );

endmodule

/* verilog/mmd_regs.vh */
/*
  Address map, configuration bit positions and reset values for the
  memory map and bus qualifier block.
  Assumes a 16-bit byte address from the core and a 20 MHz clock.
*/
`ifndef MMD_REGS_VH
`define MMD_REGS_VH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define MMD_SFR_LO        16'h0000
`define MMD_SFR_HI        16'h0017
`define MMD_RAM_LO        16'h0018
`define MMD_RAM_HI        16'h01FF
`define MMD_RAM_BYTES     488
`define MMD_LOWEXT_LO     16'h0200
`define MMD_LOWEXT_HI     16'h1FFD
`define MMD_PORT_LO       16'h1FFE
`define MMD_PORT_HI       16'h1FFF
`define MMD_PROG_LO       16'h2000
`define MMD_PROG_EA_LO    16'h2080
`define MMD_PROG_HI       16'h5FFF
`define MMD_EXT_LO        16'h6000
`define MMD_EXT_HI        16'hFFFF
`define MMD_NMI_VECTOR    16'h203E

// ----------------------------------------------------------------
// Chip configuration register fields
// ----------------------------------------------------------------
`define MMD_CFG_WRMODE    0
`define MMD_CFG_DYNWIDTH  1
`define MMD_CFG_WIDTH     8
`define MMD_CFG_RESET     8'h00

// ----------------------------------------------------------------
// Region codes
// ----------------------------------------------------------------
`define MMD_RGN_SFR       3'h0
`define MMD_RGN_RAM       3'h1
`define MMD_RGN_PORT      3'h2
`define MMD_RGN_PROG      3'h3
`define MMD_RGN_EXT       3'h4

`endif
